// [front_panel_mode_controller.v]
// front panel operating modes, menu editing and configuration store
`timescale 1ns/1ns
`include "front_panel_defs.vh"
`default_nettype none
module front_panel_mode_controller #(
   parameter integer SHOW_CYC = `SHOW_CYCLES,
   parameter integer LAMP_CYC = `LAMP_CYCLES,
   parameter integer FLASH_CYC = `FLASH_CYCLES,
   parameter integer CFG_CYC = `CFG_CYCLES,
   parameter integer TIMEOUT_CYC = `TIMEOUT_CYCLES,
   parameter integer DEB_CYC = `DEBOUNCE_CYCLES,
   parameter integer BLINK_CYC = `BLINK_CYCLES
) (
   input wire clk_i,
   input wire reset_n_i,
   input wire btn_mode_i,
   input wire btn_inc_i,
   input wire btn_dig_i,
   input wire btn_enter_i,
   input wire aux_in_i,
   input wire [15:0] sens1_temp_i,
   input wire error_i,
   input wire dead_zone_i,
   input wire nv_rd_ack_i,
   input wire nv_rd_err_i,
   input wire [15:0] nv_rd_data_i,
   output reg nv_rd_o,
   output reg nv_wr_o,
   output reg [4:0] nv_addr_o,
   output reg [15:0] nv_wr_data_o,
   output reg [2:0] disp_src_o,
   output reg [15:0] disp_bcd_o,
   output reg [3:0] disp_digit_on_o,
   output reg disp_dp_on_o,
   output reg heat_led_o,
   output reg cool_led_o,
   output reg mode_led_o,
   output reg cfg_mode_o,
   output reg out_enable_o,
   output reg [15:0] power_o
);
   localparam [2:0] ST_INIT = 3'h0;
   localparam [2:0] ST_ERR = 3'h1;
   localparam [2:0] ST_NORM = 3'h2;
   localparam [2:0] ST_CSEL = 3'h3;
   localparam [2:0] ST_CEDIT = 3'h4;
   localparam [2:0] ST_CCONF = 3'h5;

   function [15:0] bcd2bin;
      input [15:0] b;
      reg [15:0] m;
      begin
         m = {12'h000, b[11:8]} * 16'h0064 + {12'h000, b[7:4]} * 16'h000a + {12'h000, b[3:0]};
         if (b[15:12] == `SIGN_DIGIT) begin
            bcd2bin = 16'h0000 - m;
         end else begin
            bcd2bin = m + {12'h000, b[15:12]} * 16'h03e8;
         end
      end
   endfunction

   function is_temp;
      input [4:0] i;
      begin
         is_temp = (i == 5'h00) || (i == 5'h01) || (i == 5'h10) || (i == 5'h11) ||
            (i == 5'h14) || (i == 5'h15) || (i == 5'h1a) || (i == 5'h1b);
      end
   endfunction

   function in_range;
      input [4:0] i;
      input [15:0] b;
      reg neg;
      reg [15:0] mag;
      reg [15:0] mx;
      begin
         neg = (b[15:12] == `SIGN_DIGIT);
         mag = bcd2bin({4'h0, b[11:0]}) + (neg ? 16'h0000 : {12'h000, b[15:12]} * 16'h03e8);
         case (i)
            5'h04: mx = 16'h0032;
            5'h05, 5'h07: mx = 16'h0002;
            5'h06, 5'h08: mx = 16'h0001;
            5'h09, 5'h0a, 5'h0b: mx = 16'h003f;
            5'h0c: mx = 16'h03e7;
            5'h0d: mx = 16'h007f;
            5'h17: mx = 16'h0078;
            5'h18: mx = 16'h013b;
            5'h19: mx = 16'h0140;
            default: mx = 16'h0063;
         endcase
         if ((b[11:8] > 4'h9) || (b[7:4] > 4'h9) || (b[3:0] > 4'h9) || ((b[15:12] > 4'h9) && !neg)) begin
            in_range = 1'b0;
         end else if (is_temp(i)) begin
            in_range = neg ? ((mag <= `TEMP_NEG_MAX) || ((mag == `DISABLE_MAG) && (i == `IDX_LIM2 ||
               i == `IDX_LIM3 || i == 5'h1a || i == 5'h1b))) : (mag <= `TEMP_POS_MAX);
         end else if (neg) begin
            in_range = ((i == 5'h0e) || (i == 5'h12) || (i == 5'h13)) && (mag <= mx);
         end else begin
            in_range = (mag <= mx);
         end
      end
   endfunction

   // button conditioning
   wire [3:0] btn_raw;
   wire [3:0] press;
   wire [3:0] fall;
   wire [3:0] lvl;
   assign btn_raw = {btn_enter_i, btn_dig_i, btn_inc_i, btn_mode_i};
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_btn
         reg s1_q, s2_q, stab_q, stab_d_q;
         reg [31:0] cnt_q;
         always @(posedge clk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
               s1_q <= 1'b0;
               s2_q <= 1'b0;
               stab_q <= 1'b0;
               stab_d_q <= 1'b0;
               cnt_q <= 32'h0;
            end else begin
               s1_q <= btn_raw[g];
               s2_q <= s1_q;
               stab_d_q <= stab_q;
               if (s2_q != stab_q) begin
                  if (cnt_q == DEB_CYC - 1) begin
                     stab_q <= s2_q;
                     cnt_q <= 32'h0;
                  end else begin
                     cnt_q <= cnt_q + 32'h1;
                  end
               end else begin
                  cnt_q <= 32'h0;
               end
            end
         end
         assign press[g] = stab_q & ~stab_d_q;
         assign fall[g] = ~stab_q & stab_d_q;
         assign lvl[g] = stab_q;
      end
   endgenerate

   reg aux1_q, aux2_q;
   reg [2:0] st_q;
   reg [4:0] idx_q;
   reg [15:0] edit_q;
   reg [1:0] pos_q;
   reg [31:0] tmo_q, hold_q, show_q, lamp_q, blink_cnt_q;
   reg blink_q, lamp_done_q, ld_done_q, ld_err_q, act_upd_q;
   reg [2:0] show_src_q;

   // configuration store and active copy
   wire [16*`NUM_PARAM-1:0] cfg_flat;
   wire [16*`NUM_PARAM-1:0] act_flat;
   wire commit_we = (st_q == ST_CCONF) && fall[`BTN_ENTER];
   wire st_we = commit_we || ((st_q == ST_INIT) && nv_rd_o && nv_rd_ack_i && !nv_rd_err_i);
   wire [4:0] st_addr = commit_we ? idx_q : nv_addr_o;
   wire [15:0] st_data = commit_we ? edit_q : nv_rd_data_i;
   generate
      for (g = 0; g < `NUM_PARAM; g = g + 1) begin : g_store
         localparam [4:0] ADDR = g;
         reg [15:0] cfg_q, act_q;
         always @(posedge clk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
               cfg_q <= `CFG_RST;
               act_q <= `CFG_RST;
            end else begin
               if (st_we && (st_addr == ADDR)) begin
                  cfg_q <= st_data;
               end
               if (act_upd_q) begin
                  act_q <= cfg_q;
               end
            end
         end
         assign cfg_flat[g*16 +: 16] = cfg_q;
         assign act_flat[g*16 +: 16] = act_q;
      end
   endgenerate

   wire [15:0] cfg_sel = cfg_flat[idx_q*16 +: 16];
   wire sens2_en = act_flat[`IDX_LIM2*16 +: 16] != `SENSOR_OFF;
   wire sens3_en = act_flat[`IDX_LIM3*16 +: 16] != `SENSOR_OFF;
   wire dual = act_flat[`IDX_AUXIN*16 +: 16] == `AUXIN_DUAL;
   wire [15:0] set_bcd = (dual && aux2_q) ? act_flat[`IDX_SP2*16 +: 16] : act_flat[`IDX_SP1*16 +: 16];
   wire [15:0] set_bin = bcd2bin(set_bcd);
   wire [15:0] tol_bin = bcd2bin(act_flat[`IDX_TOL*16 +: 16]);
   wire [15:0] alm_bin = bcd2bin(act_flat[`IDX_ALM*16 +: 16]);
   wire [15:0] diff = sens1_temp_i - set_bin;
   wire [15:0] adiff = diff[15] ? (16'h0000 - diff) : diff;
   wire [3:0] cur_digit = edit_q[pos_q*4 +: 4];
   wire top_sign = (pos_q == 2'h3) && is_temp(idx_q);
   wire [3:0] nxt_digit = top_sign ? ((cur_digit == 4'h0) ? 4'h1 : ((cur_digit == 4'h1) ? `SIGN_DIGIT : 4'h0)) :
      ((cur_digit >= 4'h9) ? 4'h0 : cur_digit + 4'h1);
   wire [3:0] idx_tens = (idx_q >= 5'h14) ? 4'h2 : ((idx_q >= 5'h0a) ? 4'h1 : 4'h0);
   wire [4:0] idx_ones = idx_q - {1'b0, idx_tens} * 5'h0a;
   wire [7:0] idx_disp = (idx_q == `IDX_AUXOUT) ? 8'h80 : {idx_tens, idx_ones[3:0]};

   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         aux1_q <= 1'b0;
         aux2_q <= 1'b0;
         blink_cnt_q <= 32'h0;
         blink_q <= 1'b0;
      end else begin
         aux1_q <= aux_in_i;
         aux2_q <= aux1_q;
         if (blink_cnt_q == BLINK_CYC - 1) begin
            blink_cnt_q <= 32'h0;
            blink_q <= ~blink_q;
         end else begin
            blink_cnt_q <= blink_cnt_q + 32'h1;
         end
      end
   end

   // mode state machine
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st_q <= ST_INIT;
         idx_q <= 5'h00;
         edit_q <= `START_VAL;
         pos_q <= 2'h0;
         tmo_q <= 32'h0;
         hold_q <= 32'h0;
         show_q <= 32'h0;
         lamp_q <= 32'h0;
         lamp_done_q <= 1'b0;
         ld_done_q <= 1'b0;
         ld_err_q <= 1'b0;
         act_upd_q <= 1'b0;
         show_src_q <= `SRC_S1;
         nv_rd_o <= 1'b1;
         nv_wr_o <= 1'b0;
         nv_addr_o <= 5'h00;
         nv_wr_data_o <= 16'h0000;
      end else begin
         nv_wr_o <= 1'b0;
         act_upd_q <= 1'b0;
         if ((st_q == ST_CSEL) || (st_q == ST_CEDIT) || (st_q == ST_CCONF)) begin
            if ((press != 4'h0) || lvl[`BTN_ENTER]) begin
               tmo_q <= 32'h0;
            end else begin
               tmo_q <= tmo_q + 32'h1;
            end
         end
         case (st_q)
            ST_INIT: begin
               if (lamp_q == LAMP_CYC - 1) begin
                  lamp_done_q <= 1'b1;
               end else begin
                  lamp_q <= lamp_q + 32'h1;
               end
               if (nv_rd_o && nv_rd_err_i) begin
                  nv_rd_o <= 1'b0;
                  ld_err_q <= 1'b1;
               end else if (nv_rd_o && nv_rd_ack_i) begin
                  if (nv_addr_o == `IDX_LAST) begin
                     nv_rd_o <= 1'b0;
                     ld_done_q <= 1'b1;
                  end else begin
                     nv_addr_o <= nv_addr_o + 5'h01;
                  end
               end
               if (lamp_done_q && ld_err_q) begin
                  st_q <= ST_ERR;
               end else if (lamp_done_q && ld_done_q) begin
                  st_q <= ST_NORM;
                  act_upd_q <= 1'b1;
               end
            end
            ST_ERR: begin
               st_q <= ST_ERR;
            end
            ST_NORM: begin
               if (lvl[`BTN_MODE]) begin
                  if (hold_q == CFG_CYC - 1) begin
                     st_q <= ST_CSEL;
                     idx_q <= 5'h00;
                     tmo_q <= 32'h0;
                  end else begin
                     hold_q <= hold_q + 32'h1;
                  end
               end else begin
                  hold_q <= 32'h0;
               end
               if (fall[`BTN_MODE] && (hold_q >= FLASH_CYC)) begin
                  show_src_q <= `SRC_SETP;
                  show_q <= 32'h0;
               end else if (press[`BTN_INC] && sens2_en) begin
                  show_src_q <= `SRC_S2;
                  show_q <= 32'h0;
               end else if (press[`BTN_DIG] && sens3_en) begin
                  show_src_q <= `SRC_S3;
                  show_q <= 32'h0;
               end else if (show_src_q != `SRC_S1) begin
                  if (show_q == SHOW_CYC - 1) begin
                     show_src_q <= `SRC_S1;
                  end else begin
                     show_q <= show_q + 32'h1;
                  end
               end
            end
            ST_CSEL: begin
               if (press[`BTN_MODE] || (tmo_q == TIMEOUT_CYC - 1)) begin
                  st_q <= ST_NORM;
                  act_upd_q <= 1'b1;
                  hold_q <= 32'h0;
                  show_src_q <= `SRC_S1;
               end else if (press[`BTN_ENTER]) begin
                  st_q <= ST_CEDIT;
                  edit_q <= in_range(idx_q, cfg_sel) ? cfg_sel : `DEFAULT_VAL;
                  pos_q <= 2'h0;
               end else if (press[`BTN_INC]) begin
                  idx_q <= (idx_q == `IDX_LAST) ? 5'h00 : idx_q + 5'h01;
               end else if (press[`BTN_DIG]) begin
                  idx_q <= (idx_q == 5'h00) ? `IDX_LAST : idx_q - 5'h01;
               end
            end
            ST_CEDIT: begin
               if (press[`BTN_MODE] || (tmo_q == TIMEOUT_CYC - 1)) begin
                  st_q <= ST_NORM;
                  act_upd_q <= 1'b1;
                  hold_q <= 32'h0;
                  show_src_q <= `SRC_S1;
               end else if (press[`BTN_ENTER]) begin
                  if (in_range(idx_q, edit_q)) begin
                     st_q <= ST_CCONF;
                  end else begin
                     edit_q <= `START_VAL;
                  end
               end else if (press[`BTN_INC]) begin
                  edit_q[pos_q*4 +: 4] <= nxt_digit;
               end else if (press[`BTN_DIG]) begin
                  pos_q <= pos_q + 2'h1;
               end
            end
            ST_CCONF: begin
               if (press[`BTN_MODE] || (tmo_q == TIMEOUT_CYC - 1)) begin
                  st_q <= ST_NORM;
                  act_upd_q <= 1'b1;
                  hold_q <= 32'h0;
                  show_src_q <= `SRC_S1;
               end else if (fall[`BTN_ENTER]) begin
                  nv_wr_o <= 1'b1;
                  nv_addr_o <= idx_q;
                  nv_wr_data_o <= edit_q;
                  st_q <= ST_CSEL;
               end
            end
            default: begin
               st_q <= ST_INIT;
            end
         endcase
      end
   end

   // registered display, led and power outputs
   reg [2:0] src_d;
   reg [15:0] bcd_d;
   reg [3:0] blink_d;
   always @* begin
      src_d = `SRC_S1;
      bcd_d = 16'h0000;
      blink_d = 4'h0;
      case (st_q)
         ST_INIT: begin
            src_d = `SRC_LAMP;
            bcd_d = `LAMP_PATTERN;
         end
         ST_ERR: begin
            src_d = `SRC_ERR;
            bcd_d = `CONFIG_LOAD_ERROR_CODE;
         end
         ST_NORM: begin
            src_d = show_src_q;
            bcd_d = set_bcd;
         end
         ST_CSEL: begin
            src_d = `SRC_MENU;
            bcd_d = {`DASH_DIGIT, `DASH_DIGIT, idx_disp};
            blink_d = 4'h8;
         end
         ST_CEDIT: begin
            src_d = `SRC_PARAM;
            bcd_d = edit_q;
            blink_d = 4'h1 << pos_q;
         end
         ST_CCONF: begin
            src_d = `SRC_PARAM;
            bcd_d = edit_q;
            blink_d = 4'hf;
         end
         default: begin
            src_d = `SRC_S1;
         end
      endcase
   end

   wire run = (st_q == ST_NORM) && !error_i;
   wire ind = (st_q != ST_INIT) && (st_q != ST_ERR);
   wire led_on = dead_zone_i ? 1'b1 : ((adiff > alm_bin) ? blink_q : (adiff > tol_bin));
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         disp_src_o <= `SRC_LAMP;
         disp_bcd_o <= `LAMP_PATTERN;
         disp_digit_on_o <= 4'hf;
         disp_dp_on_o <= 1'b1;
         heat_led_o <= 1'b0;
         cool_led_o <= 1'b0;
         mode_led_o <= 1'b0;
         cfg_mode_o <= 1'b0;
         out_enable_o <= 1'b0;
         power_o <= 16'h0000;
      end else begin
         disp_src_o <= src_d;
         disp_bcd_o <= bcd_d;
         disp_digit_on_o <= ~(blink_d & {4{blink_q}});
         disp_dp_on_o <= (st_q == ST_INIT);
         heat_led_o <= ind && led_on && (dead_zone_i || diff[15]);
         cool_led_o <= ind && led_on && (dead_zone_i || !diff[15]);
         mode_led_o <= ((st_q == ST_NORM) && (hold_q >= FLASH_CYC)) ? blink_q : (st_q == ST_CSEL ||
            st_q == ST_CEDIT || st_q == ST_CCONF);
         cfg_mode_o <= (st_q == ST_CSEL) || (st_q == ST_CEDIT) || (st_q == ST_CCONF);
         out_enable_o <= run;
         power_o <= run ? (set_bin - sens1_temp_i) : 16'h0000;
      end
   end
endmodule
`default_nettype wire

// [front_panel_defs.vh]
// constants for the front panel mode controller
`ifndef FRONT_PANEL_DEFS_VH
`define FRONT_PANEL_DEFS_VH
`define CLK_KHZ 10000
`define SHOW_TIME_MS 3000
`define LAMP_TIME_MS 1000
`define FLASH_TIME_MS 1000
`define CFG_TIME_MS 3000
`define TIMEOUT_TIME_MS 10000
`define DEBOUNCE_TIME_MS 10
`define BLINK_TIME_MS 250
`define SHOW_CYCLES (`SHOW_TIME_MS * `CLK_KHZ)
`define LAMP_CYCLES (`LAMP_TIME_MS * `CLK_KHZ)
`define FLASH_CYCLES (`FLASH_TIME_MS * `CLK_KHZ)
`define CFG_CYCLES (`CFG_TIME_MS * `CLK_KHZ)
`define TIMEOUT_CYCLES (`TIMEOUT_TIME_MS * `CLK_KHZ)
`define DEBOUNCE_CYCLES (`DEBOUNCE_TIME_MS * `CLK_KHZ)
`define BLINK_CYCLES (`BLINK_TIME_MS * `CLK_KHZ)
`define NUM_PARAM 29
`define IDX_LAST 5'h1c
`define IDX_SP1 5'h00
`define IDX_SP2 5'h01
`define IDX_TOL 5'h02
`define IDX_ALM 5'h03
`define IDX_AUXIN 5'h07
`define IDX_AUXOUT 5'h08
`define IDX_LIM2 5'h10
`define IDX_LIM3 5'h11
`define CFG_RST 16'h0000
`define DEFAULT_VAL 16'h0000
`define START_VAL 16'h0000
`define SIGN_DIGIT 4'ha
`define DASH_DIGIT 4'hb
`define SENSOR_OFF 16'ha999
`define AUXIN_DUAL 16'h0002
`define TEMP_NEG_MAX 16'h02ee
`define TEMP_POS_MAX 16'h06d6
`define DISABLE_MAG 16'h03e7
`define CONFIG_LOAD_ERROR_CODE 16'he100
`define LAMP_PATTERN 16'h8888
`define SRC_S1 3'h0
`define SRC_SETP 3'h1
`define SRC_S2 3'h2
`define SRC_S3 3'h3
`define SRC_MENU 3'h4
`define SRC_PARAM 3'h5
`define SRC_ERR 3'h6
`define SRC_LAMP 3'h7
`define BTN_MODE 0
`define BTN_INC 1
`define BTN_DIG 2
`define BTN_ENTER 3
`endif

// [front_panel_mode_controller_chk.sv]
// port checker for the front panel mode controller
`timescale 1ns/1ns
`include "front_panel_defs.vh"
`default_nettype none
module front_panel_chk #(
   parameter integer TIMEOUT_CYC = 100
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic btn_mode_i,
   input wire logic btn_inc_i,
   input wire logic btn_dig_i,
   input wire logic btn_enter_i,
   input wire logic error_i,
   input wire logic nv_rd_o,
   input wire logic nv_wr_o,
   input wire logic [4:0] nv_addr_o,
   input wire logic [2:0] disp_src_o,
   input wire logic [15:0] disp_bcd_o,
   input wire logic disp_dp_on_o,
   input wire logic cfg_mode_o,
   input wire logic out_enable_o,
   input wire logic [15:0] power_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   // cycles spent in configuration with no button down
   logic [15:0] idle_q;
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) idle_q <= 16'h0000;
      else if (!cfg_mode_o || btn_mode_i || btn_inc_i || btn_dig_i || btn_enter_i) idle_q <= 16'h0000;
      else idle_q <= idle_q + 16'h0001;
   end
   property p_lamp; disp_src_o == `SRC_LAMP |-> disp_bcd_o == `LAMP_PATTERN && disp_dp_on_o; endproperty
   a_lamp: assert property (p_lamp) else $error("lamp test pattern wrong");
   property p_err_code; disp_src_o == `SRC_ERR |-> disp_bcd_o == `CONFIG_LOAD_ERROR_CODE && !out_enable_o; endproperty
   a_err_code: assert property (p_err_code) else $error("load error display wrong");
   property p_err_stays; disp_src_o == `SRC_ERR |=> disp_src_o == `SRC_ERR; endproperty
   a_err_stays: assert property (p_err_stays) else $error("load error state left");
   property p_load_off; nv_rd_o |-> !out_enable_o; endproperty
   a_load_off: assert property (p_load_off) else $error("outputs on while loading");
   property p_fault_off; error_i [*3] |-> !out_enable_o; endproperty
   a_fault_off: assert property (p_fault_off) else $error("outputs on during fault");
   property p_power_off; !out_enable_o |-> power_o == 16'h0000; endproperty
   a_power_off: assert property (p_power_off) else $error("power set while disabled");
   property p_cfg_off; cfg_mode_o |-> !out_enable_o; endproperty
   a_cfg_off: assert property (p_cfg_off) else $error("outputs on in configuration");
   property p_menu; $rose(cfg_mode_o) |-> disp_src_o == `SRC_MENU && disp_bcd_o[15:8] == 8'hbb; endproperty
   a_menu: assert property (p_menu) else $error("menu screen not shown");
   property p_wr; nv_wr_o |-> cfg_mode_o ##1 !nv_wr_o; endproperty
   a_wr: assert property (p_wr) else $error("store write outside configuration");
   property p_index; nv_addr_o <= `IDX_LAST; endproperty
   a_index: assert property (p_index) else $error("parameter index beyond last");
   property p_timeout; idle_q <= TIMEOUT_CYC + 8; endproperty
   a_timeout: assert property (p_timeout) else $error("configuration did not time out");
endmodule
`default_nettype wire

// [front_panel_operator.sv]
// operator buttons and nonvolatile store facing the controller
`timescale 1ns/1ns
`default_nettype none
module front_panel_operator (
   input wire logic clk_i,
   input wire logic nv_rd_i,
   input wire logic nv_wr_i,
   input wire logic [4:0] nv_addr_i,
   input wire logic [15:0] nv_wr_data_i,
   input wire logic fail_i,
   input wire logic slow_i,
   output logic [3:0] btn_o,
   output logic nv_rd_ack_o,
   output logic nv_rd_err_o,
   output logic [15:0] nv_rd_data_o,
   output logic [7:0] wr_count_o
);
   logic [15:0] mem [0:28];
   initial begin
      btn_o = 4'h0;
      nv_rd_ack_o = 1'b0;
      nv_rd_err_o = 1'b0;
      wr_count_o = 8'h00;
      for (int i = 0; i < 29; i++) mem[i] = 16'h0000;
      mem[0] = 16'h0250;
      mem[1] = 16'h0300;
      mem[7] = 16'h0002;
      mem[16] = 16'ha999;
      mem[17] = 16'h0300;
   end
   // data lines carry the inverse when no word is offered
   assign nv_rd_data_o = nv_rd_ack_o ? mem[nv_addr_i] : ~mem[nv_addr_i];
   always @(posedge clk_i) begin
      nv_rd_ack_o <= nv_rd_i && !fail_i && !(slow_i && nv_rd_ack_o);
      nv_rd_err_o <= nv_rd_i && fail_i && !nv_rd_err_o;
      if (nv_wr_i) begin
         mem[nv_addr_i] <= nv_wr_data_i;
         wr_count_o <= wr_count_o + 8'h01;
      end
   end
   // one held level per press, then a quiet gap
   task press(input int b, input int hold);
      @(posedge clk_i);
      btn_o[b] <= 1'b1;
      repeat (hold) @(posedge clk_i);
      btn_o[b] <= 1'b0;
      repeat (10) @(posedge clk_i);
   endtask
endmodule
`default_nettype wire

// [front_panel_mode_controller_bench.sv]
// self-checking bench for the front panel mode controller
`timescale 1ns/1ns
`include "front_panel_defs.vh"
`default_nettype none
module front_panel_mode_controller_bench;
   logic clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic aux_in_i = 1'b0;
   logic error_i = 1'b0;
   logic dead_zone_i = 1'b0;
   logic fail = 1'b0;
   logic slow = 1'b1;
   logic [15:0] sens1_temp_i = 16'h00c8;
   logic [7:0] lfsr = 8'h51;
   wire [3:0] btn;
   wire btn_mode_i = btn[`BTN_MODE];
   wire btn_inc_i = btn[`BTN_INC];
   wire btn_dig_i = btn[`BTN_DIG];
   wire btn_enter_i = btn[`BTN_ENTER];
   wire nv_rd_ack_i, nv_rd_err_i, nv_rd_o, nv_wr_o, disp_dp_on_o, heat_led_o, cool_led_o, mode_led_o;
   wire cfg_mode_o, out_enable_o;
   wire [15:0] nv_rd_data_i, nv_wr_data_o, disp_bcd_o, power_o;
   wire [4:0] nv_addr_o;
   wire [2:0] disp_src_o;
   wire [3:0] disp_digit_on_o;
   wire [7:0] wr_count;
   integer errors = 0;
   integer compares = 0;
   integer cycles = 0;
   integer k;
   front_panel_mode_controller #(.SHOW_CYC(30), .LAMP_CYC(10), .FLASH_CYC(20), .CFG_CYC(40), .TIMEOUT_CYC(100),
      .DEB_CYC(3), .BLINK_CYC(5)) i_front_panel_mode_controller (.clk_i, .reset_n_i, .btn_mode_i, .btn_inc_i,
      .btn_dig_i, .btn_enter_i, .aux_in_i, .sens1_temp_i, .error_i, .dead_zone_i, .nv_rd_ack_i, .nv_rd_err_i,
      .nv_rd_data_i, .nv_rd_o, .nv_wr_o, .nv_addr_o, .nv_wr_data_o, .disp_src_o, .disp_bcd_o, .disp_digit_on_o,
      .disp_dp_on_o, .heat_led_o, .cool_led_o, .mode_led_o, .cfg_mode_o, .out_enable_o, .power_o);
   front_panel_operator i_front_panel_operator (.clk_i(clk_i), .nv_rd_i(nv_rd_o), .nv_wr_i(nv_wr_o),
      .nv_addr_i(nv_addr_o), .nv_wr_data_i(nv_wr_data_o), .fail_i(fail), .slow_i(slow), .btn_o(btn),
      .nv_rd_ack_o(nv_rd_ack_i), .nv_rd_err_o(nv_rd_err_i), .nv_rd_data_o(nv_rd_data_i), .wr_count_o(wr_count));
   initial begin
      forever #50 clk_i = ~clk_i;
   end
   function automatic logic [7:0] next_rand(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   // bcd set value in tenths minus actual temperature
   function automatic logic [15:0] exp_power(input logic [15:0] sp, input logic [15:0] act);
      return sp[11:8] * 16'h0064 + sp[7:4] * 16'h000a + sp[3:0] - act;
   endfunction
   task chk(input logic [15:0] got, input logic [15:0] exp);
      compares = compares + 1;
      if (got !== exp) begin
         errors = errors + 1;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task wait_src(input logic [2:0] e, input int lim);
      for (int n = 0; n < lim && disp_src_o !== e; n++) @(negedge clk_i);
      chk(disp_src_o, e);
   endtask
   task push(input int b, input int hold);
      i_front_panel_operator.press(b, hold);
      @(negedge clk_i);
   endtask
   task final_report;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         errors = errors + 1;
         final_report;
      end
   end
   initial begin
      @(negedge clk_i);
      chk(disp_src_o, `SRC_LAMP);
      chk(out_enable_o, 1'b0);
      @(posedge clk_i);
      reset_n_i <= 1'b1;
      wait_src(`SRC_S1, 200);
      repeat (3) @(negedge clk_i);
      chk(out_enable_o, 1'b1);
      for (k = 0; k < 8; k++) begin
         lfsr = next_rand(lfsr);
         @(posedge clk_i);
         sens1_temp_i <= k == 0 ? 16'hff38 : {8'h00, lfsr};
         aux_in_i <= k[0];
         error_i <= lfsr[7] & lfsr[6];
         dead_zone_i <= lfsr[5];
         repeat (8) @(negedge clk_i);
         chk(power_o, error_i ? 16'h0000 : exp_power(k[0] ? 16'h0300 : 16'h0250, sens1_temp_i));
         chk(out_enable_o, !error_i);
         if (dead_zone_i) chk({heat_led_o, cool_led_o}, 2'b11);
      end
      @(posedge clk_i);
      aux_in_i <= 1'b0;
      dead_zone_i <= 1'b1;
      repeat (4) @(negedge clk_i);
      chk({heat_led_o, cool_led_o}, 2'b11);
      @(posedge clk_i);
      error_i <= 1'b1;
      repeat (4) @(negedge clk_i);
      chk(out_enable_o, 1'b0);
      @(posedge clk_i);
      error_i <= 1'b0;
      dead_zone_i <= 1'b0;
      push(`BTN_INC, 4);
      chk(disp_src_o, `SRC_S1);
      push(`BTN_DIG, 4);
      chk(disp_src_o, `SRC_S3);
      repeat (40) @(negedge clk_i);
      chk(disp_src_o, `SRC_S1);
      push(`BTN_MODE, 30);
      wait_src(`SRC_SETP, 10);
      chk(disp_bcd_o, 16'h0250);
      repeat (40) @(negedge clk_i);
      chk(disp_src_o, `SRC_S1);
      push(`BTN_MODE, 60);
      chk(cfg_mode_o, 1'b1);
      chk(disp_bcd_o, 16'hbb00);
      chk(out_enable_o, 1'b0);
      chk(mode_led_o, 1'b1);
      chk(disp_digit_on_o[2:0], 3'h7);
      push(`BTN_DIG, 4);
      chk(disp_bcd_o, 16'hbb28);
      push(`BTN_INC, 4);
      for (k = 1; k < 10; k++) begin
         push(`BTN_INC, 4);
         chk(disp_bcd_o, k == 8 ? 16'hbb80 : {12'hbb0, k[3:0]});
      end
      for (k = 0; k < 9; k++) push(`BTN_DIG, 4);
      push(`BTN_ENTER, 4);
      chk(disp_src_o, `SRC_PARAM);
      chk(disp_bcd_o, 16'h0250);
      push(`BTN_INC, 4);
      chk(disp_bcd_o, 16'h0251);
      push(`BTN_ENTER, 10);
      chk(wr_count, 8'h01);
      chk(i_front_panel_operator.mem[0], 16'h0251);
      chk(disp_src_o, `SRC_MENU);
      push(`BTN_ENTER, 4);
      push(`BTN_INC, 4);
      push(`BTN_MODE, 4);
      chk(cfg_mode_o, 1'b0);
      chk(wr_count, 8'h01);
      push(`BTN_MODE, 30);
      chk(disp_bcd_o, 16'h0251);
      chk(power_o, exp_power(16'h0251, sens1_temp_i));
      push(`BTN_MODE, 60);
      push(`BTN_INC, 4);
      push(`BTN_ENTER, 4);
      for (k = 0; k < 3; k++) push(`BTN_DIG, 4);
      for (k = 0; k < 4; k++) begin
         push(`BTN_INC, 4);
         chk(disp_bcd_o, {k == 1 ? 4'ha : k == 2 ? 4'h0 : 4'h1, 12'h300});
      end
      for (k = 0; k < 3; k++) push(`BTN_DIG, 4);
      for (k = 0; k < 5; k++) push(`BTN_INC, 4);
      chk(disp_bcd_o, 16'h1800);
      push(`BTN_ENTER, 4);
      chk(disp_src_o, `SRC_PARAM);
      chk(disp_bcd_o, `START_VAL);
      chk(wr_count, 8'h01);
      repeat (130) @(negedge clk_i);
      chk(cfg_mode_o, 1'b0);
      @(posedge clk_i);
      reset_n_i <= 1'b0;
      slow <= lfsr[2];
      repeat (2) @(posedge clk_i);
      reset_n_i <= 1'b1;
      wait_src(`SRC_S1, 200);
      @(posedge clk_i);
      reset_n_i <= 1'b0;
      fail <= 1'b1;
      repeat (2) @(posedge clk_i);
      reset_n_i <= 1'b1;
      wait_src(`SRC_ERR, 50);
      chk(disp_bcd_o, `CONFIG_LOAD_ERROR_CODE);
      chk(out_enable_o, 1'b0);
      final_report;
   end
endmodule
bind front_panel_mode_controller front_panel_chk #(.TIMEOUT_CYC(TIMEOUT_CYC)) i_front_panel_chk (.clk_i, .reset_n_i,
   .btn_mode_i, .btn_inc_i, .btn_dig_i, .btn_enter_i, .error_i, .nv_rd_o, .nv_wr_o, .nv_addr_o, .disp_src_o,
   .disp_bcd_o, .disp_dp_on_o, .cfg_mode_o, .out_enable_o, .power_o);
`default_nettype wire
